// *** pkt_queue_map.vh ***
// constants for the packet queue, serializer and pattern detector
`ifndef PKT_QUEUE_MAP_VH
`define PKT_QUEUE_MAP_VH
`define Q_DEPTH      7'h40
`define Q_EMPTY      7'h00
`define Q_ONE        7'h01
`define PTR_ONE      6'h01
`define MODE_SLEEP   3'h0
`define MODE_STBY    3'h1
`define MODE_TX      3'h3
`define MODE_RX      3'h5
`define PRE_BYTE     8'hAA
`define PRE_LAST     3'h2
`define BIT_LAST     3'h7
`define BIT_ONE      3'h1
`define BYTE_ZERO    8'h00
`define CNT_ONE      11'h001
`define LEN_SHORT_HI 3'h0
`define ALL_ONES     64'hFFFFFFFFFFFFFFFF
`define ALL_ZERO     64'h0000000000000000
`define BYTE_SHIFT   3'h0
`endif

// *** packet_fifo_sync_detect.v ***
// byte queue with serializer, frame builder and pattern detector
// Overview of operation
// (RULE1) 64-entry byte-wide queue for tx and rx
// (RULE2) host reaches queue only via spi strobes
// (RULE3) tx serializer shifts bytes out msb first
// (RULE4) rx serializer assembles bits into queue bytes
// (RULE5) empty flag updated on chip-select falling edge
// (RULE6) full flag high when all entries used
// (RULE7) push into full queue sets overflow, drops
// (RULE8) writing one clears overflow and flushes queue
// (RULE9) frame done after final bit shifted out
// (RULE10) level flag recomputed only on queue access
// (RULE11) level frozen from full until queue empty
// (RULE12) mode change flushes or keeps queue per table
// (RULE13) rx to standby or sleep keeps contents
// (RULE14) host waits for mode settled after sleep
// (RULE15) detection needs enable and bit synchronizer
// (RULE16) detector shifts bits and compares with pattern
// (RULE17) first bit meets msb of first byte
// (RULE18) match cleared leaving rx or queue emptied; emptying the queue by an overflow clear flush leaves match set
// (RULE19) pattern length one to eight bytes
// (RULE20) 64-bit pattern also used for tx
// (RULE21) host never programs zero pattern bytes
// (RULE22) frame built and stripped, payload length limited
`timescale 1ns/1ps
`include "pkt_queue_map.vh"
module packet_fifo_sync_detect (
  input  wire        clk_in,
  input  wire        sys_rst_in,
  input  wire [2:0]  mode_in,
  input  wire        packet_mode_in,
  input  wire        host_wr_in,
  input  wire [7:0]  host_wdata_in,
  input  wire        host_rd_in,
  input  wire        cs_n_in,
  input  wire        overflow_clr_in,
  input  wire [5:0]  queue_level_threshold_in,
  input  wire        pattern_detect_enable_in,
  input  wire        bit_sync_host_in,
  input  wire [2:0]  pattern_length_in,
  input  wire [63:0] pattern_value_in,
  input  wire [10:0] payload_len_in,
  input  wire        long_len_in,
  input  wire        unlimited_in,
  input  wire        bit_clk_in,
  input  wire        rx_bit_in,
  output wire [7:0]  host_rdata_out,
  output wire        queue_drained_out,
  output wire        queue_brimming_out,
  output wire        queue_overflow_flag_out,
  output wire        queue_level_irq_out,
  output wire        frame_tx_done_out,
  output wire        pattern_match_flag_out,
  output wire        mode_settled_out,
  output wire        bit_sync_en_out,
  output wire        tx_bit_out
);
  localparam TX_IDLE = 2'h0;
  localparam TX_PRE  = 2'h1;
  localparam TX_SYNC = 2'h2;
  localparam TX_PAY  = 2'h3;
  reg [7:0]  mem [0:63];
  reg [5:0]  wp_q;
  reg [5:0]  rp_q;
  reg [6:0]  cnt_q;
  reg [7:0]  rdata_q;
  reg        drained_q;
  reg        brim_q;
  reg        ovf_q;
  reg        level_q;
  reg        hold_q;
  reg        done_q;
  reg        match_q;
  reg        settled_q;
  reg        bsync_q;
  reg [2:0]  mode_q;
  reg        cs_s1_q;
  reg        cs_s2_q;
  reg        cs_s3_q;
  reg        bc_s1_q;
  reg        bc_s2_q;
  reg        bc_s3_q;
  reg        rx_s1_q;
  reg        rx_s2_q;
  reg [1:0]  tx_st_q;
  reg [7:0]  tx_sh_q;
  reg [2:0]  tx_bit_q;
  reg [10:0] tx_cnt_q;
  reg        tx_out_q;
  reg [63:0] rx_sr_q;
  reg        rx_pay_q;
  reg [2:0]  rx_bit_q;
  reg [7:0]  rx_byte_q;
  reg [10:0] rx_cnt_q;
  // synchronised pins and their edges
  wire       cs_fall  = cs_s3_q & ~cs_s2_q;
  wire       tick     = bc_s2_q & ~bc_s3_q;
  wire       chg      = mode_in != mode_q;
  wire       in_tx    = mode_q == `MODE_TX;
  wire       in_rx    = mode_q == `MODE_RX;
  wire       full     = cnt_q == `Q_DEPTH;
  wire       empty    = cnt_q == `Q_EMPTY;
  wire [10:0] lim     = long_len_in ? payload_len_in : {`LEN_SHORT_HI, payload_len_in[7:0]};
  wire       byte_end = tx_bit_q == `BIT_LAST;
  // mode change flush table
  wire flush_mode = chg & (in_tx | (mode_in == `MODE_RX) | (in_rx & (mode_in == `MODE_TX))); // RULE12 RULE13
  wire flush      = flush_mode | overflow_clr_in; // RULE8
  // pattern compare, first received bit against msb of first byte
  wire [63:0] rx_sr_d = {rx_sr_q[62:0], rx_s2_q};
  wire [5:0]  pshift  = {~pattern_length_in, `BYTE_SHIFT}; // RULE19
  wire [63:0] pmask   = `ALL_ONES >> pshift;
  wire [63:0] pexp    = pattern_value_in >> pshift; // RULE17 RULE20
  wire        detect  = pattern_detect_enable_in & bsync_q; // RULE15
  wire        hit     = (((rx_sr_d ^ pexp) & pmask) == `ALL_ZERO); // RULE16
  // tx byte loading
  wire [2:0] nidx   = (tx_st_q == TX_PRE) ? 3'h0 : tx_cnt_q[2:0] + `BIT_ONE;
  wire [7:0] pbyte  = pattern_value_in[{~nidx, `BYTE_SHIFT} +: 8]; // RULE20
  wire       tx_busy = tx_st_q != TX_IDLE;
  wire       sync_last = tx_cnt_q[2:0] == pattern_length_in;
  wire       pay_last  = unlimited_in ? empty : ((tx_cnt_q + `CNT_ONE) >= lim); // RULE22
  wire       tx_load_pay = tick & tx_busy & in_tx & byte_end &
                           (((tx_st_q == TX_SYNC) & sync_last) | ((tx_st_q == TX_PAY) & ~pay_last));
  wire [7:0] qhead = empty ? `BYTE_ZERO : mem[rp_q];
  // rx byte completion
  wire       rx_push  = tick & in_rx & rx_pay_q & (rx_bit_q == `BIT_LAST); // RULE4
  wire [7:0] rx_byte_d = {rx_byte_q[6:0], rx_s2_q};
  // queue access, host strobes come from the spi logic on this clock
  wire host_push = host_wr_in & ~in_rx; // RULE2
  wire host_pop  = host_rd_in & ~in_tx; // RULE2
  wire push      = host_push | rx_push;
  wire push_ok   = push & ~full & ~flush; // RULE7
  wire pop_ok    = (host_pop | tx_load_pay) & ~empty & ~flush;
  wire [7:0] din = rx_push ? rx_byte_d : host_wdata_in;
  wire [6:0] cnt_d = flush ? `Q_EMPTY :
                     (push_ok & ~pop_ok) ? cnt_q + `Q_ONE :
                     (pop_ok & ~push_ok) ? cnt_q - `Q_ONE : cnt_q;
  wire       hold_d = (cnt_d == `Q_DEPTH) | (hold_q & (cnt_d != `Q_EMPTY)); // RULE11
  assign host_rdata_out          = rdata_q;
  assign queue_drained_out       = drained_q;
  assign queue_brimming_out      = brim_q;
  assign queue_overflow_flag_out = ovf_q;
  assign queue_level_irq_out     = level_q;
  assign frame_tx_done_out       = done_q;
  assign pattern_match_flag_out  = match_q;
  assign mode_settled_out        = settled_q;
  assign bit_sync_en_out         = bsync_q;
  assign tx_bit_out              = tx_out_q;
  // pin synchronisers
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      bc_s1_q <= 1'b0;
      bc_s2_q <= 1'b0;
      bc_s3_q <= 1'b0;
      rx_s1_q <= 1'b0;
      rx_s2_q <= 1'b0;
    end else begin
      cs_s1_q <= cs_n_in;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      bc_s1_q <= bit_clk_in;
      bc_s2_q <= bc_s1_q;
      bc_s3_q <= bc_s2_q;
      rx_s1_q <= rx_bit_in;
      rx_s2_q <= rx_s1_q;
    end
  end
  // queue storage
  always @(posedge clk_in) begin
    if (push_ok) begin
      mem[wp_q] <= din; // RULE1
    end
  end
  // queue pointers and flags
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wp_q      <= 6'h00;
      rp_q      <= 6'h00;
      cnt_q     <= `Q_EMPTY;
      rdata_q   <= `BYTE_ZERO;
      drained_q <= 1'b1;
      brim_q    <= 1'b0;
      ovf_q     <= 1'b0;
      level_q   <= 1'b0;
      hold_q    <= 1'b0;
      mode_q    <= `MODE_SLEEP;
      settled_q <= 1'b1;
      bsync_q   <= 1'b0;
    end else begin
      mode_q  <= mode_in;
      bsync_q <= packet_mode_in | bit_sync_host_in; // RULE15
      settled_q <= ~chg & (~tx_busy | (mode_in == `MODE_TX)); // RULE14
      if (flush) begin
        wp_q <= 6'h00;
        rp_q <= 6'h00;
      end else begin
        if (push_ok) begin
          wp_q <= wp_q + `PTR_ONE;
        end
        if (pop_ok) begin
          rp_q <= rp_q + `PTR_ONE;
        end
      end
      if (pop_ok & host_pop) begin
        rdata_q <= mem[rp_q];
      end
      cnt_q  <= cnt_d;
      brim_q <= cnt_d == `Q_DEPTH; // RULE6
      if (cs_fall | flush | rx_push | tx_load_pay) begin
        drained_q <= cnt_d == `Q_EMPTY; // RULE5
      end
      if (push & full) begin
        ovf_q <= 1'b1; // RULE7
      end else if (overflow_clr_in) begin
        ovf_q <= 1'b0; // RULE8
      end
      hold_q <= hold_d;
      if (flush) begin
        level_q <= 1'b0;
      end else if ((push_ok | pop_ok) & ~hold_d) begin
        level_q <= cnt_d > {1'b0, queue_level_threshold_in}; // RULE10 RULE11
      end
    end
  end
  // transmit frame builder and serializer
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_st_q  <= TX_IDLE;
      tx_sh_q  <= `BYTE_ZERO;
      tx_bit_q <= 3'h0;
      tx_cnt_q <= 11'h000;
      tx_out_q <= 1'b0;
      done_q   <= 1'b0;
    end else begin
      if (tick & tx_busy & byte_end & (tx_st_q == TX_PAY) & pay_last & in_tx) begin
        done_q <= 1'b1; // RULE9
      end else if (chg & in_tx) begin
        done_q <= 1'b0;
      end
      if (tick) begin
        if (~tx_busy) begin
          tx_bit_q <= 3'h0;
          tx_cnt_q <= 11'h000;
          if (in_tx & ~done_q & ~empty) begin
            tx_st_q <= TX_PRE; // RULE22
            tx_sh_q <= `PRE_BYTE;
          end
        end else if (~in_tx) begin
          tx_st_q <= TX_IDLE;
        end else begin
          tx_out_q <= tx_sh_q[7]; // RULE3
          tx_sh_q  <= {tx_sh_q[6:0], 1'b0};
          tx_bit_q <= tx_bit_q + `BIT_ONE;
          if (byte_end) begin
            case (tx_st_q)
              TX_PRE: begin
                if (tx_cnt_q[2:0] == `PRE_LAST) begin
                  tx_st_q  <= TX_SYNC;
                  tx_cnt_q <= 11'h000;
                  tx_sh_q  <= pbyte; // RULE19
                end else begin
                  tx_cnt_q <= tx_cnt_q + `CNT_ONE;
                  tx_sh_q  <= `PRE_BYTE;
                end
              end
              TX_SYNC: begin
                if (sync_last) begin
                  tx_st_q  <= TX_PAY;
                  tx_cnt_q <= 11'h000;
                  tx_sh_q  <= qhead;
                end else begin
                  tx_cnt_q <= tx_cnt_q + `CNT_ONE;
                  tx_sh_q  <= pbyte;
                end
              end
              TX_PAY: begin
                if (pay_last) begin
                  tx_st_q <= TX_IDLE; // RULE9
                end else begin
                  tx_cnt_q <= tx_cnt_q + `CNT_ONE;
                  tx_sh_q  <= qhead;
                end
              end
              default: begin
                tx_st_q <= TX_IDLE;
              end
            endcase
          end
        end
      end
    end
  end
  // receive pattern hunt and payload assembly
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_sr_q   <= `ALL_ZERO;
      rx_pay_q  <= 1'b0;
      rx_bit_q  <= 3'h0;
      rx_byte_q <= `BYTE_ZERO;
      rx_cnt_q  <= 11'h000;
      match_q   <= 1'b0;
    end else begin
      if (tick & in_rx & ~rx_pay_q & detect & hit) begin
        match_q <= 1'b1; // RULE16
      end else if ((chg & in_rx) | (pop_ok & (cnt_d == `Q_EMPTY))) begin
        match_q <= 1'b0; // RULE18
      end
      if (~in_rx) begin
        rx_pay_q <= 1'b0;
        rx_sr_q  <= `ALL_ZERO;
      end else if (tick) begin
        rx_sr_q <= rx_sr_d; // RULE16
        if (~rx_pay_q) begin
          rx_bit_q <= 3'h0;
          rx_cnt_q <= 11'h000;
          if (detect & hit) begin
            rx_pay_q <= 1'b1; // RULE22
          end
        end else begin
          rx_byte_q <= rx_byte_d; // RULE4
          rx_bit_q  <= rx_bit_q + `BIT_ONE;
          if (rx_bit_q == `BIT_LAST) begin
            rx_cnt_q <= rx_cnt_q + `CNT_ONE;
            if (~unlimited_in & ((rx_cnt_q + `CNT_ONE) >= lim)) begin
              rx_pay_q <= 1'b0; // RULE22
            end
          end
        end
      end
    end
  end

endmodule

// *** queue_props.sv ***
// port assertions for the packet queue block
`timescale 1ns/1ps
`include "pkt_queue_map.vh"
module queue_props (
  input wire logic       clk_in,
  input wire logic       sys_rst_in,
  input wire logic [2:0] mode_in,
  input wire logic       host_wr_in,
  input wire logic       host_rd_in,
  input wire logic       overflow_clr_in,
  input wire logic       pattern_detect_enable_in,
  input wire logic [7:0] host_rdata_out,
  input wire logic       queue_drained_out,
  input wire logic       queue_brimming_out,
  input wire logic       queue_overflow_flag_out,
  input wire logic       queue_level_irq_out,
  input wire logic       pattern_match_flag_out
);
  wire sb = mode_in == `MODE_STBY;
  wire pf = queue_brimming_out && host_rd_in && !host_wr_in && !overflow_clr_in && sb;
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  ovf_set_a: assert property (
    queue_brimming_out && host_wr_in && !host_rd_in && sb && $stable(mode_in) |=> queue_overflow_flag_out)
    else $error("write into full queue left overflow low");
  flush_clr_a: assert property (
    overflow_clr_in && !host_wr_in && sb && $stable(mode_in) |=>
    !queue_overflow_flag_out && !queue_brimming_out && !queue_level_irq_out && queue_drained_out)
    else $error("overflow clear did not flush queue");
  read_ref_a: assert property (
    host_rd_in && mode_in == `MODE_TX && $stable(mode_in) |=> $stable(host_rdata_out))
    else $error("read accepted in tx mode");
  level_hold_a: assert property (
    sb && $stable(mode_in) && !host_wr_in && !host_rd_in && !overflow_clr_in |=> $stable(queue_level_irq_out))
    else $error("level changed without queue access");
  brim_drop_a: assert property (
    pf && $stable(mode_in) |=> !queue_brimming_out)
    else $error("full flag stayed after pop");
  level_frz_a: assert property (
    pf && $stable(mode_in) |=> $stable(queue_level_irq_out))
    else $error("level moved while frozen after full");
  detect_off_a: assert property (
    !pattern_detect_enable_in && $stable(pattern_detect_enable_in) && !pattern_match_flag_out
    |=> !pattern_match_flag_out)
    else $error("match set with detection off");
  match_clr_a: assert property (
    pattern_match_flag_out && mode_in != `MODE_RX |-> ##[1:3] !pattern_match_flag_out)
    else $error("match flag kept outside rx");
endmodule
bind packet_fifo_sync_detect queue_props props_i (.clk_in, .sys_rst_in, .mode_in, .host_wr_in, .host_rd_in,
  .overflow_clr_in, .pattern_detect_enable_in, .host_rdata_out, .queue_drained_out, .queue_brimming_out,
  .queue_overflow_flag_out, .queue_level_irq_out, .pattern_match_flag_out);

// *** link_far_end.sv ***
// link-side model: bit clock, demodulated bits, tx capture
`timescale 1ns/1ps
module link_far_end (
  input  wire logic        run_in,
  input  wire logic [63:0] rx_word_in,
  input  wire logic        tx_bit_in,
  output logic             bit_clk_out,
  output logic             rx_bit_out,
  output logic [63:0]      tx_cap_out
);
  logic [63:0] sh_q;
  always begin
    if (!run_in) begin
      bit_clk_out = 1'b0;
      rx_bit_out = (rx_bit_out !== 1'b1);
      sh_q = rx_word_in;
      #24;
    end else begin
      rx_bit_out = sh_q[63];
      #24 bit_clk_out = 1'b1;
      tx_cap_out = {tx_cap_out[62:0], tx_bit_in};
      #24 bit_clk_out = 1'b0;
      sh_q = {sh_q[62:0], 1'b0};
    end
  end
endmodule

// *** testbench.sv ***
// self-checking bench for the packet queue block
`timescale 1ns/1ps
module testbench;
  logic        clk_in = 0, sys_rst_in = 1, host_wr_in = 0, host_rd_in = 0, cs_n_in = 1;
  logic        overflow_clr_in = 0, pattern_detect_enable_in = 0, run = 0, packet_mode_in = 1;
  logic [2:0]  mode_in = 0, pattern_length_in = 0;
  logic [5:0]  queue_level_threshold_in = 0;
  logic [7:0]  host_wdata_in = 0;
  logic [63:0] pattern_value_in = 0;
  wire  [7:0]  host_rdata_out;
  wire         queue_drained_out, queue_brimming_out, queue_overflow_flag_out, queue_level_irq_out;
  wire         frame_tx_done_out, pattern_match_flag_out, bit_clk, rx_bit, tx_bit, mode_settled_out, bit_sync_en_out;
  wire  [63:0] tx_cap;
  int          miscompares = 0, check_count = 0;
  packet_fifo_sync_detect uut (.clk_in, .sys_rst_in, .mode_in, .packet_mode_in, .host_wr_in,
    .host_wdata_in, .host_rd_in, .cs_n_in, .overflow_clr_in, .queue_level_threshold_in,
    .pattern_detect_enable_in, .bit_sync_host_in(1'b0), .pattern_length_in, .pattern_value_in,
    .payload_len_in(11'h001), .long_len_in(1'b0), .unlimited_in(1'b0), .bit_clk_in(bit_clk),
    .rx_bit_in(rx_bit), .host_rdata_out, .queue_drained_out, .queue_brimming_out, .queue_overflow_flag_out,
    .queue_level_irq_out, .frame_tx_done_out, .pattern_match_flag_out, .mode_settled_out,
    .bit_sync_en_out, .tx_bit_out(tx_bit));
  link_far_end far (.run_in(run), .rx_word_in(64'hAA5CE1C300000000), .tx_bit_in(tx_bit),
    .bit_clk_out(bit_clk), .rx_bit_out(rx_bit), .tx_cap_out(tx_cap));
  initial forever #2.5 clk_in = ~clk_in;
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge clk_in);
    host_wr_in <= 1;
    host_wdata_in <= d;
    @(posedge clk_in);
    host_wr_in <= 0;
  endtask
  task automatic rd(input logic [7:0] e);
    @(posedge clk_in);
    host_rd_in <= 1;
    @(posedge clk_in);
    host_rd_in <= 0;
    tick(1);
    #1 chk(host_rdata_out, e);
  endtask
  task automatic sel();
    @(posedge clk_in);
    cs_n_in <= 0;
    tick(5);
    cs_n_in <= 1;
    #1;
  endtask
  task automatic setm(input logic [2:0] m);
    @(posedge clk_in);
    mode_in <= m;
    tick(3);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    pattern_value_in = 64'h5CE13A7BC4D6E8F9;
    tick(6);
    sys_rst_in <= 0;
    setm(3'h1);
    chk({mode_settled_out, bit_sync_en_out}, 2'h3);
    wr(8'h11);
    tick(1);
    #1 chk(queue_level_irq_out, 1);
    queue_level_threshold_in <= 6'h3F;
    tick(3);
    #1 chk(queue_level_irq_out, 1);
    sel();
    chk(queue_drained_out, 0);
    wr(8'h01);
    tick(1);
    #1 chk(queue_level_irq_out, 0);
    for (int i = 2; i < 64; i++) wr(i[7:0]);
    tick(1);
    #1 chk(queue_brimming_out, 1);
    wr(8'hEE);
    tick(1);
    #1 chk(queue_overflow_flag_out, 1);
    rd(8'h11);
    chk(queue_brimming_out, 0);
    @(posedge clk_in);
    overflow_clr_in <= 1;
    @(posedge clk_in);
    overflow_clr_in <= 0;
    tick(1);
    #1 chk({queue_overflow_flag_out, queue_brimming_out, queue_drained_out}, 3'h1);
    rd(8'h11);
    wr(8'hB4);
    setm(3'h3);
    rd(8'h11);
    run = 1;
    for (int n = 0; n < 2000 && frame_tx_done_out !== 1'b1; n++) tick(1);
    if (frame_tx_done_out !== 1'b1) begin
      miscompares++;
      end_sim();
    end
    @(posedge bit_clk);
    #30 run = 0;
    chk(tx_cap[39:0], {24'hAAAAAA, 8'h5C, 8'hB4});
    setm(3'h1);
    chk(frame_tx_done_out, 0);
    packet_mode_in <= 0;
    tick(2);
    #1 chk(bit_sync_en_out, 0);
    packet_mode_in <= 1;
    wr(8'h77);
    pattern_length_in <= 3'h1;
    pattern_detect_enable_in <= 1;
    setm(3'h5);
    run = 1;
    repeat (32) @(posedge bit_clk);
    run = 0;
    tick(20);
    chk(pattern_match_flag_out, 1);
    setm(3'h1);
    chk(pattern_match_flag_out, 0);
    @(posedge clk_in);
    mode_in <= 3'h0;
    tick(1);
    #1 chk(mode_settled_out, 0);
    for (int n = 0; n < 20 && mode_settled_out !== 1'b1; n++) tick(1);
    chk(mode_settled_out, 1);
    rd(8'hC3);
    rd(8'hC3);
    sel();
    chk(queue_drained_out, 1);
    end_sim();
  end
endmodule
